//--- hdl/mfir_consts.svh
// register offsets, status field layout and reset values of the filter
// assumes inclusion by bare name from the filter top and the bench
`ifndef MFIR_CONSTS_SVH
`define MFIR_CONSTS_SVH

`define MFIR_AW        4
`define MFIR_REG_CFG   4'h0
`define MFIR_REG_RIDX  4'h4
`define MFIR_REG_RDAT  4'h8
`define MFIR_REG_STAT  4'hc
`define MFIR_ST_CFGP   0
`define MFIR_ST_RLDP   1
`define MFIR_ST_FSEL   8
`define MFIR_ST_CH     16
`define MFIR_ST_CNT    24
`define MFIR_FLD_W     8
`define MFIR_RST_RDATA 32'h0000_0000

`endif

//--- hdl/mfir_pkg.sv
// state type used by the filter top
// assumes nothing of its surroundings
package mfir_pkg;
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_PHASE = 2'b01,
    ST_MAC   = 2'b10,
    ST_EMIT  = 2'b11
  } mfir_state_t;
endpackage

//--- hdl/mfir_fifo.sv
// input sample buffer with valid/ready on both sides
// assumes one clock; clock enable freezes it
`timescale 1ns/1ps
`default_nettype none
module mfir_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 16
) (
  input  wire logic                       clk_i,       // clock
  input  wire logic                       rst_i,       // sync reset
  input  wire logic                       ce_i,        // clock enable
  input  wire logic                       in_valid_i,  // write offer
  output logic                            in_ready_o,  // room left
  input  wire logic [W-1:0]               in_data_i,   // write word
  output logic                            out_valid_o, // word present
  input  wire logic                       out_ready_i, // drain
  output logic [W-1:0]                    out_data_o,  // head word
  output logic [$clog2(DEPTH+1)-1:0]      count_o      // words held
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  generate
    if (DEPTH < 2) begin : g_bad
      $error("mfir_fifo: DEPTH below 2");
    end
  endgenerate

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [PW-1:0]           wp;
    logic [PW-1:0]           rp;
    logic [CW-1:0]           cnt;
    logic                    rdy;
  } mfir_fifo_st_t;

  mfir_fifo_st_t s_q;
  mfir_fifo_st_t s_d;
  logic          push;
  logic          pull;

  function automatic logic [PW-1:0] inc(input logic [PW-1:0] p);
    inc = (p == PW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  always_comb begin
    s_d  = s_q;
    push = ce_i && in_valid_i && s_q.rdy;
    pull = ce_i && out_ready_i && (s_q.cnt != '0);
    if (push) begin
      s_d.mem[s_q.wp] = in_data_i;
      s_d.wp          = inc(s_q.wp);
    end
    if (pull) begin
      s_d.rp = inc(s_q.rp);
    end
    s_d.cnt = s_q.cnt + CW'(push) - CW'(pull);
    // registered so the upstream ready never depends on our drain path
    s_d.rdy = (s_d.cnt < CW'(DEPTH));
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q     <= '0;
      s_q.rdy <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign in_ready_o  = s_q.rdy;
  assign out_valid_o = (s_q.cnt != '0);
  assign out_data_o  = s_q.mem[s_q.rp];
  assign count_o     = s_q.cnt;

  a_fifo_full: assert property (@(posedge clk_i) disable iff (rst_i) // [RULE12]
    !in_ready_o |-> count_o == CW'(DEPTH))
    else $error("fifo refuses data while not full");
endmodule
`default_nettype wire

//--- hdl/mfir_mac.sv
// one path's sum of products over the taps handled in one cycle
// assumes operands already selected and zeroed where unused
`timescale 1ns/1ps
`default_nettype none
module mfir_mac #(
  parameter int TPC     = 1,
  parameter int DW      = 16,
  parameter int CW      = 16,
  parameter int ACCW    = 40,
  parameter bit CSIGNED = 1'b1
) (
  input  wire logic [TPC-1:0][DW-1:0] d_i,   // data operands
  input  wire logic [TPC-1:0][CW-1:0] c_i,   // coefficient operands
  output logic      [ACCW-1:0]        sum_o  // partial sum
);
  always_comb begin
    logic signed [CW:0]    cx;
    logic signed [DW+CW:0] prod;
    cx    = '0;
    prod  = '0;
    sum_o = '0;
    for (int u = 0; u < TPC; u++) begin
      cx    = $signed({CSIGNED & c_i[u][CW-1], c_i[u]}); // [RULE14]
      prod  = $signed(d_i[u]) * cx;
      sum_o = sum_o + ACCW'(prod);
    end
  end
endmodule
`default_nettype wire

//--- hdl/mfir_top.sv
// multichannel resampling fir filter with stream ports and register port
// assumes stream partners and register master share SYS_CLK_I
// Function
// [RULE1] set select exists only for several sets
// [RULE2] sets stored concatenated, equal length each
// [RULE3] supplied coefficient count divisible by set count
// [RULE4] reloaded coefficients wait for sync event
// [RULE5] interpolation multiplies output rate by P
// [RULE6] decimation divides output rate by Q
// [RULE7] fractional mode resamples by P over Q
// [RULE8] zero packing spaces taps by k
// [RULE9] up to 64 interleaved channels
// [RULE10] parallel paths split the data word
// [RULE11] oversampling rate sets taps per cycle
// [RULE12] input valid is an exposed handshake
// [RULE13] coefficients match chosen symmetry structure; the code has no symmetry structure and multiplies every tap on its own
// [RULE14] signed or unsigned fixed point coefficients
// [RULE15] config applied at channel sequence start
// [RULE16] packet last flag follows the datapath
// [RULE17] output is per-channel sum of products
//
// The placing of the registers and the address-and-strobe port are this design's own decisions.
`include "mfir_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module mfir_top #(
  parameter int NCH        = 1,
  parameter int NPATH      = 1,
  parameter int DW         = 16,
  parameter int CW         = 16,
  parameter int NSETS      = 1,
  parameter int NTAPS      = 8,
  parameter int P          = 1,
  parameter int Q          = 1,
  parameter int K          = 1,
  parameter int OSR        = 1,
  parameter bit COEF_SIGNED = 1'b1,
  parameter int COEF_FRAC  = 0,
  parameter int FIFO_DEPTH = 16,
  parameter logic [NSETS*NTAPS*CW-1:0] COEF_INIT = '0
) (
  input  wire logic                      SYS_CLK_I,       // 20 MHz clock
  input  wire logic                      SYS_RST_I,       // sync reset
  input  wire logic                      CE_I,            // clock enable
  input  wire logic [NPATH*DW-1:0]       S_AXIS_TDATA_I,  // samples
  input  wire logic                      S_AXIS_TVALID_I, // sample valid
  input  wire logic                      S_AXIS_TLAST_I,  // packet last
  output logic                           S_AXIS_TREADY_O, // buffer room
  output logic [NPATH*(DW+CW+1+$clog2((NTAPS+P-1)/P+1))-1:0] M_AXIS_TDATA_O, // results
  output logic                           M_AXIS_TVALID_O, // result valid
  output logic                           M_AXIS_TLAST_O,  // packet last
  output logic [7:0]                     M_AXIS_TUSER_O,  // channel id
  input  wire logic                      M_AXIS_TREADY_I, // result taken
  input  wire logic [`MFIR_AW-1:0]       REG_ADDR_I,      // register addr
  input  wire logic [31:0]               REG_WDATA_I,     // write data
  input  wire logic                      REG_WR_I,        // write strobe
  input  wire logic                      REG_RD_I,        // read strobe
  output logic [31:0]                    REG_RDATA_O      // read data
);
  // ---------------------------------------------------------------
  // derived sizes
  // ---------------------------------------------------------------
  localparam int JMAX = (NTAPS + P - 1) / P;
  localparam int TPC  = (JMAX + OSR - 1) / OSR;
  localparam int HD   = JMAX * K;
  localparam int ACCW = DW + CW + 1 + $clog2(JMAX + 1);
  localparam int NCO  = NSETS * NTAPS;
  localparam int CHW  = (NCH > 1) ? $clog2(NCH) : 1;
  localparam int FSW  = (NSETS > 1) ? $clog2(NSETS) : 1;
  localparam int QW   = (Q > 1) ? $clog2(Q) : 1;
  localparam int PW   = (P > 1) ? $clog2(P) : 1;
  localparam int OCW  = (OSR > 1) ? $clog2(OSR) : 1;
  localparam int CIW  = (NCO > 1) ? $clog2(NCO) : 1;
  localparam int FCW  = $clog2(FIFO_DEPTH + 1);

  // COEF_INIT is sized NSETS*NTAPS words, so sets are equal by build
  generate
    if (NCH < 1 || NCH > 64 || NSETS < 1 || NSETS > 256 || NTAPS < 1 // [RULE9] [RULE3]
        || P < 1 || P > 256 || Q < 1 || Q > 256 || K < 1 || OSR < 1
        || OSR > JMAX || NPATH < 1 || FIFO_DEPTH < 2 || FCW > 8
        || COEF_FRAC < 0 || COEF_FRAC >= ACCW) begin : g_bad
      $error("mfir_top: parameter out of supported range");
    end
  endgenerate

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    mfir_pkg::mfir_state_t                  st;
    logic [NCO-1:0][CW-1:0]                 coef;
    logic [NCO-1:0][CW-1:0]                 shad;
    logic [CIW-1:0]                         ridx;
    logic                                   rld_pend;
    logic                                   cfg_pend;
    logic [FSW-1:0]                         cfg_fsel;
    logic [FSW-1:0]                         fsel;
    logic [CHW-1:0]                         ch;
    logic [CHW-1:0]                         cur;
    logic [NCH-1:0][QW-1:0]                 ph;
    logic [PW-1:0]                          pp;
    logic [OCW-1:0]                         cyc;
    logic                                   last;
    logic [NPATH-1:0][ACCW-1:0]             acc;
    logic [NCH-1:0][NPATH-1:0][HD-1:0][DW-1:0] hist;
    logic                                   ovalid;
    logic                                   olast;
    logic [CHW-1:0]                         ochan;
    logic [NPATH-1:0][ACCW-1:0]             odata;
    logic [31:0]                            rdata;
  } mfir_st_t;

  mfir_st_t                          s_q;
  mfir_st_t                          s_d;
  logic                              f_valid;
  logic                              pop;
  logic                              adv;
  logic                              emit;
  logic [NPATH*DW:0]                 f_data;
  logic [FCW-1:0]                    f_cnt;
  logic [NPATH-1:0][TPC-1:0][DW-1:0] opd;
  logic [NPATH-1:0][TPC-1:0][CW-1:0] opc;
  logic [NPATH-1:0][ACCW-1:0]        psum;

  // ---------------------------------------------------------------
  // input buffer and multiply-accumulate paths
  // ---------------------------------------------------------------
  mfir_fifo #(
    .W     (NPATH*DW+1),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_i       (SYS_CLK_I),
    .rst_i       (SYS_RST_I),
    .ce_i        (CE_I),
    .in_valid_i  (S_AXIS_TVALID_I), // [RULE12]
    .in_ready_o  (S_AXIS_TREADY_O),
    .in_data_i   ({S_AXIS_TLAST_I, S_AXIS_TDATA_I}),
    .out_valid_o (f_valid),
    .out_ready_i (pop),
    .out_data_o  (f_data),
    .count_o     (f_cnt)
  );

  genvar gp;
  generate
    for (gp = 0; gp < NPATH; gp++) begin : g_path
      mfir_mac #(
        .TPC     (TPC),
        .DW      (DW),
        .CW      (CW),
        .ACCW    (ACCW),
        .CSIGNED (COEF_SIGNED)
      ) u_mac (
        .d_i   (opd[gp]),
        .c_i   (opc[gp]),
        .sum_o (psum[gp])
      );
    end
  endgenerate

  // operand selection: taps of the current polyphase branch
  always_comb begin
    int j;
    int ci;
    j   = 0;
    ci  = 0;
    opd = '0;
    opc = '0;
    for (int p = 0; p < NPATH; p++) begin
      for (int u = 0; u < TPC; u++) begin
        j  = int'(s_q.cyc) * TPC + u; // [RULE11]
        ci = int'(s_q.pp) + j * P; // [RULE5] [RULE7]
        if (j < JMAX && ci < NTAPS) begin
          opd[p][u] = s_q.hist[s_q.cur][p][j*K]; // [RULE8] [RULE17]
          opc[p][u] = s_q.coef[int'(s_q.fsel)*NTAPS+ci]; // [RULE2]
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    s_d      = s_q;
    pop      = 1'b0;
    adv      = 1'b0;
    emit     = 1'b0;
    s_d.rdata = `MFIR_RST_RDATA;
    if (CE_I) begin
      if (s_q.ovalid && M_AXIS_TREADY_I) begin
        s_d.ovalid = 1'b0;
      end
      case (s_q.st)
        mfir_pkg::ST_IDLE: begin
          if (f_valid) begin
            pop      = 1'b1;
            s_d.cur  = s_q.ch;
            s_d.last = f_data[NPATH*DW];
            s_d.ch   = (s_q.ch == CHW'(NCH-1)) ? '0 : s_q.ch + 1'b1; // [RULE9]
            // sync event: start of the interleaved channel sequence
            if (s_q.ch == '0 && s_q.cfg_pend) begin // [RULE15]
              s_d.fsel     = s_q.cfg_fsel;
              s_d.cfg_pend = 1'b0;
              if (s_q.rld_pend) begin
                s_d.coef     = s_q.shad; // [RULE4]
                s_d.rld_pend = 1'b0;
              end
            end
            for (int p = 0; p < NPATH; p++) begin
              for (int h = HD - 1; h > 0; h--) begin
                s_d.hist[s_q.ch][p][h] = s_q.hist[s_q.ch][p][h-1];
              end
              s_d.hist[s_q.ch][p][0] = f_data[p*DW +: DW]; // [RULE10]
            end
            s_d.pp = '0;
            s_d.st = mfir_pkg::ST_PHASE;
          end
        end
        mfir_pkg::ST_PHASE: begin
          // only every Q-th upsampled point is computed at all
          if (s_q.ph[s_q.cur] == '0) begin // [RULE6]
            s_d.acc = '0;
            s_d.cyc = '0;
            s_d.st  = mfir_pkg::ST_MAC;
          end else begin
            adv = 1'b1;
          end
        end
        mfir_pkg::ST_MAC: begin
          for (int p = 0; p < NPATH; p++) begin
            s_d.acc[p] = s_q.acc[p] + psum[p]; // [RULE17]
          end
          if (s_q.cyc == OCW'(OSR-1)) begin // [RULE11]
            s_d.st = mfir_pkg::ST_EMIT;
          end else begin
            s_d.cyc = s_q.cyc + 1'b1;
          end
        end
        mfir_pkg::ST_EMIT: begin
          // waits here while the downstream holds back
          if (!s_q.ovalid || M_AXIS_TREADY_I) begin
            emit       = 1'b1;
            s_d.ovalid = 1'b1;
            s_d.olast  = s_q.last; // [RULE16]
            s_d.ochan  = s_q.cur;
            for (int p = 0; p < NPATH; p++) begin
              s_d.odata[p] = ACCW'($signed(s_q.acc[p]) >>> COEF_FRAC); // [RULE14]
            end
            adv = 1'b1;
          end
        end
        default: begin
          s_d.st = mfir_pkg::ST_IDLE;
        end
      endcase
      if (adv) begin
        s_d.ph[s_q.cur] = (s_q.ph[s_q.cur] == QW'(Q-1)) ? '0 // [RULE6] [RULE7]
                          : s_q.ph[s_q.cur] + 1'b1;
        if (s_q.pp == PW'(P-1)) begin // [RULE5]
          s_d.st = mfir_pkg::ST_IDLE;
        end else begin
          s_d.pp = s_q.pp + 1'b1;
          s_d.st = mfir_pkg::ST_PHASE;
        end
      end
      // register writes come last so a new request beats a consume
      if (REG_WR_I) begin
        if (REG_ADDR_I == `MFIR_REG_CFG) begin
          s_d.cfg_pend = 1'b1;
          s_d.cfg_fsel = (NSETS > 1) ? FSW'(REG_WDATA_I) : '0; // [RULE1]
        end else if (REG_ADDR_I == `MFIR_REG_RIDX) begin
          s_d.ridx = '0;
        end else if (REG_ADDR_I == `MFIR_REG_RDAT) begin
          s_d.shad[s_q.ridx] = CW'(REG_WDATA_I);
          if (s_q.ridx == CIW'(NCO-1)) begin
            s_d.ridx     = '0;
            s_d.rld_pend = 1'b1; // [RULE4]
          end else begin
            s_d.ridx = s_q.ridx + 1'b1;
          end
        end
      end
      if (REG_RD_I) begin
        if (REG_ADDR_I == `MFIR_REG_CFG) begin
          s_d.rdata = 32'(s_q.cfg_fsel);
        end else if (REG_ADDR_I == `MFIR_REG_RIDX) begin
          s_d.rdata = 32'(s_q.ridx);
        end else if (REG_ADDR_I == `MFIR_REG_STAT) begin
          s_d.rdata[`MFIR_ST_CFGP] = s_q.cfg_pend;
          s_d.rdata[`MFIR_ST_RLDP] = s_q.rld_pend;
          s_d.rdata[`MFIR_ST_FSEL +: `MFIR_FLD_W] = `MFIR_FLD_W'(s_q.fsel);
          s_d.rdata[`MFIR_ST_CH +: `MFIR_FLD_W]   = `MFIR_FLD_W'(s_q.ch);
          s_d.rdata[`MFIR_ST_CNT +: `MFIR_FLD_W]  = `MFIR_FLD_W'(f_cnt);
        end
      end
    end
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (SYS_RST_I) begin
      s_q      <= '0;
      s_q.coef <= COEF_INIT;
      s_q.shad <= COEF_INIT;
    end else begin
      s_q <= s_d;
    end
  end

  assign M_AXIS_TVALID_O = s_q.ovalid;
  assign M_AXIS_TLAST_O  = s_q.olast;
  assign M_AXIS_TUSER_O  = 8'(s_q.ochan);
  assign M_AXIS_TDATA_O  = s_q.odata;
  assign REG_RDATA_O     = s_q.rdata;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  logic [8:0] ecnt_q;
  logic       seen_q;

  always_ff @(posedge SYS_CLK_I) begin
    if (SYS_RST_I) begin
      ecnt_q <= '0;
      seen_q <= 1'b0;
    end else if (CE_I) begin
      if (pop) begin
        ecnt_q <= '0;
        seen_q <= 1'b1;
      end else if (emit) begin
        ecnt_q <= ecnt_q + 1'b1;
      end
    end
  end

  default clocking cb @(posedge SYS_CLK_I);
  endclocking
  default disable iff (SYS_RST_I || !CE_I);

  sequence s_skip;
    s_q.st == mfir_pkg::ST_PHASE && s_q.ph[s_q.cur] != '0;
  endsequence

  sequence s_emit_then_out;
    emit ##1 M_AXIS_TVALID_O;
  endsequence

  a_fsel_single: assert property ((NSETS > 1) || (s_q.fsel == '0)) // [RULE1]
    else $error("set select moved with a single set");

  a_coef_deferred: assert property ($changed(s_q.coef) |-> // [RULE4]
    $past(pop && s_q.ch == '0 && s_q.cfg_pend && s_q.rld_pend))
    else $error("coefficients changed outside a sync event");

  a_cfg_vector: assert property ($changed(s_q.fsel) |-> // [RULE15]
    $past(pop && s_q.ch == '0))
    else $error("set select applied mid sequence");

  a_interp_count: assert property ((Q == 1 && pop && seen_q) |-> // [RULE5]
    ecnt_q == 9'(P))
    else $error("output count per input differs from P");

  a_rate_bound: assert property (ecnt_q <= 9'((P + Q - 1) / Q)) // [RULE7]
    else $error("too many outputs for one input");

  a_decim_skip: assert property (s_skip |=> s_q.st != mfir_pkg::ST_MAC) // [RULE6]
    else $error("computed a decimated-away point");

  a_chan_range: assert property (s_q.ch <= CHW'(NCH-1)) // [RULE9]
    else $error("channel counter beyond channel count");

  a_mac_len: assert property ($fell(s_q.st == mfir_pkg::ST_MAC) |-> // [RULE11]
    $past(s_q.cyc) == OCW'(OSR-1) && s_q.st == mfir_pkg::ST_EMIT)
    else $error("accumulation did not last OSR cycles");

  a_last_fwd: assert property (s_emit_then_out |-> // [RULE16]
    M_AXIS_TLAST_O == $past(s_q.last))
    else $error("last flag not carried with result");
endmodule
`default_nettype wire

//--- bench/mfir_sink.sv
// downstream stream sink model facing the filter output
// assumes one clock shared with the filter
`timescale 1ns/1ps
`default_nettype none
module mfir_sink (
  input  wire logic       clk_i,   // clock
  input  wire logic       rst_i,   // sync reset
  input  wire logic [1:0] mode_i,  // 0 prompt, 1 slow, 2 hold
  input  wire logic       valid_i, // result offered
  output logic            ready_o, // result accepted
  output logic            take_o   // transfer at next edge
);
  // slow mode is ready on about one cycle in four
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ready_o <= 1'b0;
    end else begin
      ready_o <= (mode_i == 2'h0) || (mode_i == 2'h1 && $urandom_range(3) == 0);
    end
  end
  assign take_o = valid_i & ready_o;
endmodule
`default_nettype wire

//--- bench/mfir_top_tb.sv
// self-checking bench for the multichannel fir filter
// assumes mfir_top, mfir_sink and the register constants header
`include "mfir_consts.svh"
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, x, y) begin check_count++; if ((x) !== (y)) begin n_errors++; \
  $display("MISMATCH %s exp %h got %h", n, x, y); end end
module mfir_top_tb;
  localparam int NCH = 2, NP = 2, NT = 4, P = 2, Q = 3, K = 2;
  localparam int DW = 8, CW = 8, NS = 2;
  localparam logic [63:0] CI = 64'h07fd05ff_04030201;
  logic        clk = 1'b0, rst = 1'b1, vld = 1'b0, lst = 1'b0;
  logic        ce  = 1'b1;
  logic        wrs = 1'b0, rds = 1'b0, srdy, mvld, mlst, mrdy, take;
  logic [15:0] dat = 16'h0;
  logic [3:0]  adr = 4'h0;
  logic [31:0] wd  = 32'h0, rdata, st;
  logic [37:0] mdat;
  logic [7:0]  muser;
  logic [1:0]  mode = 2'h0;
  logic [46:0] e;
  logic [46:0] exq[$];
  int          n_errors = 0, check_count = 0;
  int          coef[8], shadow[8], hist[NCH][NP][4], cnt[NCH];
  int          act = 0, pend = 0, nch = 0, i;
  bit          cfgp = 0, rldp = 0, ce_rand = 0;

  always #25 clk = ~clk;

  // clock enable drops at random only while ce_rand is set
  always @(posedge clk) ce <= !ce_rand || ($urandom_range(3) != 0);

  mfir_top #(.NCH(NCH), .NPATH(NP), .DW(DW), .CW(CW), .NSETS(NS), .NTAPS(NT), .P(P), .Q(Q),
    .K(K), .OSR(1), .COEF_SIGNED(1'b1), .COEF_FRAC(0), .FIFO_DEPTH(16), .COEF_INIT(CI)) dut (
    .SYS_CLK_I(clk), .SYS_RST_I(rst), .CE_I(ce), .S_AXIS_TDATA_I(dat),
    .S_AXIS_TVALID_I(vld), .S_AXIS_TLAST_I(lst), .S_AXIS_TREADY_O(srdy),
    .M_AXIS_TDATA_O(mdat), .M_AXIS_TVALID_O(mvld), .M_AXIS_TLAST_O(mlst),
    .M_AXIS_TUSER_O(muser), .M_AXIS_TREADY_I(mrdy), .REG_ADDR_I(adr), .REG_WDATA_I(wd),
    .REG_WR_I(wrs), .REG_RD_I(rds), .REG_RDATA_O(rdata));
  mfir_sink u_sink (.clk_i(clk), .rst_i(rst), .mode_i(mode), .valid_i(mvld),
    .ready_o(mrdy), .take_o(take));

  // ------------------------------------------------------------
  // reference model
  // ------------------------------------------------------------
  task automatic model(input logic [15:0] d, input logic l);
    int ch, s, y, p, j, t;
    logic [46:0] ev;
    begin
      ch = nch;
      nch = (nch + 1) % NCH;
      if (ch == 0 && cfgp) begin
        act = pend;
        cfgp = 0;
        if (rldp) begin
          coef = shadow;
          rldp = 0;
        end
      end
      for (s = 0; s < NP; s++) begin
        for (t = 3; t > 0; t--) hist[ch][s][t] = hist[ch][s][t-1];
        hist[ch][s][0] = $signed(d[s*8+:8]);
      end
      for (p = 0; p < P; p++) begin
        if (cnt[ch] == 0) begin
          ev = {l, 8'(ch), 38'h0};
          for (s = 0; s < NP; s++) begin
            y = 0;
            for (j = 0; j < 2; j++)
              if (p + j * P < NT) y += coef[act*NT+p+j*P] * hist[ch][s][j*K];
            ev[s*19+:19] = 19'(y);
          end
          exq.push_back(ev);
        end
        cnt[ch] = (cnt[ch] + 1) % Q;
      end
    end
  endtask

  // upstream drives valid itself and holds it until taken or for at most 40 cycles, then gives up
  task automatic burst(input int n);
    int k, w;
    bit r;
    begin
      for (k = 0; k < n; k++) begin
        if ($urandom_range(2) == 0) begin
          vld <= 1'b0;
          @(posedge clk);
        end
        vld <= 1'b1;
        dat <= 16'($urandom);
        lst <= 1'($urandom);
        r = 0;
        for (w = 0; w < 40 && !r; w++) begin
          @(negedge clk);
          r = srdy && ce;
          @(posedge clk);
        end
        if (!r) break;
        model(dat, lst);
      end
      vld <= 1'b0;
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    begin
      adr <= a;
      wd <= d;
      wrs <= 1'b1;
      @(posedge clk);
      wrs <= 1'b0;
      @(posedge clk);
    end
  endtask

  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    begin
      adr <= a;
      rds <= 1'b1;
      @(posedge clk);
      rds <= 1'b0;
      @(negedge clk);
      d = rdata;
      @(posedge clk);
    end
  endtask

  task automatic drain();
    int w;
    begin
      for (w = 0; w < 3000 && exq.size() != 0; w++) @(posedge clk);
      repeat (8) @(posedge clk);
      `CHK("left", 0, exq.size())
    end
  endtask

  task automatic test_done();
    begin
      $display("checks %0d mismatches %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0)
        $display("[ PASS ]");
      else
        $display("[ FAIL ]");
      $finish;
    end
  endtask

  always @(negedge clk) begin
    if (!rst && take && ce) begin
      e = (exq.size() != 0) ? exq.pop_front() : '1;
      `CHK("tdata", e[37:0], mdat)
      `CHK("tuser", e[45:38], muser)
      `CHK("tlast", e[46], mlst)
    end
  end

  initial begin
    repeat (30000) @(posedge clk);
    n_errors++;
    test_done();
  end

  // ------------------------------------------------------------
  // test sequence
  // ------------------------------------------------------------
  initial begin
    void'($urandom(32'hb9fd55da));
    for (i = 0; i < 8; i++) coef[i] = $signed(CI[i*8+:8]);
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    `CHK("s_ready", 1'b1, srdy)
    @(posedge clk);
    burst(12);
    drain();
    $display("test basic done");
    mode <= 2'h1;
    ce_rand <= 1'b1;
    burst(20);
    ce_rand <= 1'b0;
    drain();
    $display("test stall done");
    mode <= 2'h2;
    burst(24);
    @(negedge clk);
    `CHK("full", 1'b0, srdy)
    @(posedge clk);
    rd(`MFIR_REG_STAT, st);
    `CHK("fifo_cnt", 8'h10, st[31:24])
    mode <= 2'h0;
    drain();
    $display("test fill done");
    if (nch == 0) burst(1);
    drain();
    wr(`MFIR_REG_CFG, 32'h1);
    pend = 1;
    cfgp = 1;
    rd(`MFIR_REG_STAT, st);
    `CHK("cfg_pend", 1'b1, st[0])
    burst(4);
    drain();
    rd(`MFIR_REG_STAT, st);
    `CHK("set", 8'h01, st[15:8])
    $display("test config done");
    wr(`MFIR_REG_RIDX, 32'h0);
    for (i = 0; i < 8; i++) begin
      shadow[i] = $signed(8'($urandom));
      wr(`MFIR_REG_RDAT, 32'(shadow[i]) & 32'h0000_00ff);
    end
    rldp = 1;
    rd(`MFIR_REG_STAT, st);
    `CHK("rld_pend", 1'b1, st[1])
    rd(`MFIR_REG_RIDX, st);
    `CHK("ridx", 32'h0, st)
    burst(6);
    drain();
    wr(`MFIR_REG_CFG, 32'h0);
    pend = 0;
    cfgp = 1;
    burst(8);
    drain();
    rd(4'h2, st);
    `CHK("unmapped", 32'h0, st)
    $display("test reload done");
    test_done();
  end
endmodule
`default_nettype wire
